// File: rtl/cfg_loader_defs.svh
// Constants for the power-up configuration loader.
// Assumes inclusion by bare name from the loader package and module.
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

// Number of stored configurations and index width
`define CFG_COUNT        4
`define CFG_IDX_W        2
// Configuration word width
`define CFG_WORD_W       32
// Clock rate in kHz
`define CLK_KHZ          50000
// Quiet time after power-up before select pins may move, in ms
`define STARTUP_MS       10
// Settle time after a select change, in ms
`define SETTLE_MS        1
// Derived cycle counts
`define STARTUP_CYC      (`STARTUP_MS * `CLK_KHZ)
`define SETTLE_CYC       (`SETTLE_MS * `CLK_KHZ)
// Power-on reset stretch in cycles
`define POR_CYC          16
// Reset value of the bus default configuration word
`define BUS_DEFAULT_RST  32'h0000_0000

`endif

// File: rtl/cfg_loader_pkg.sv
// Types for the power-up configuration loader.
// Assumes cfg_loader_defs.svh is on the include path.
`include "cfg_loader_defs.svh"

package cfg_loader_pkg;

	// Loader states, one-hot
	typedef enum logic [4:0] {
		ST_POR    = 5'h01,
		ST_SAMPLE = 5'h02,
		ST_LOAD   = 5'h04,
		ST_RUN    = 5'h08,
		ST_SETTLE = 5'h10
	} load_state_t;

	// Source of the active configuration
	typedef enum logic [1:0] {
		SRC_NONE  = 2'h0,
		SRC_STORE = 2'h1,
		SRC_BUS   = 2'h2
	} cfg_src_t;

	// Serial bus write request
	typedef struct packed {
		logic                    valid;
		logic [`CFG_WORD_W-1:0]  data;
	} bus_wr_t;

	// One-time store program request
	typedef struct packed {
		logic                    valid;
		logic [`CFG_IDX_W-1:0]   index;
		logic [`CFG_WORD_W-1:0]  data;
	} store_wr_t;

endpackage

// File: rtl/powerup_config_select_loader.sv
// Power-up configuration loader: mode strap, select pins, OTP bank store.
// Assumes inputs synchronous to core_clk; the block makes its own reset.
//
// Operation
// - Internal power-on reset starts load sequence
// - Strap latched at reset: low software, high hardware
// - Software mode: bus writes override loaded configuration
// - Hardware mode loads bank {hi,lo} of four
// - Select pins sampled at power-up, bank loaded
// - Hardware mode: select change reloads bank; 1ms settle time
// - Software mode: store load bit picks bus defaults or bank0
// - Banks kept in one-time-programmable store
// - Select pins double as serial bus lines
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module powerup_config_select_loader #(
	parameter int STARTUP_CYC = `STARTUP_CYC,
	parameter int SETTLE_CYC  = `SETTLE_CYC
) (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        mode_strap_pin,
	input  wire logic                        config_select_lo,
	input  wire logic                        config_select_hi,
	input  wire logic                        store_load_enable_bit,
	input  wire cfg_loader_pkg::bus_wr_t     bus_wr,
	input  wire cfg_loader_pkg::store_wr_t   store_wr,
	output logic                             hw_mode,
	output logic                             bus_enabled,
	output logic                             bus_wr_denied,
	output logic                             load_bit_rd,
	output logic [`CFG_IDX_W-1:0]            cfg_index,
	output logic [`CFG_WORD_W-1:0]           cfg_word,
	output cfg_loader_pkg::cfg_src_t         cfg_src,
	output logic                             cfg_ready,
	output logic                             align_pulse
);

	////////////////////////////////////////////////////////////////////
	// State and storage

	localparam int CW = 24; // Counter width, holds 10 ms at 50 MHz

	cfg_loader_pkg::load_state_t   st_q, st_d;        // Loader state
	logic [CW-1:0]                 cnt_q, cnt_d;      // Timer
	logic [4:0]                    por_q, por_d;      // Power-on stretch
	logic                          por_done_q, por_done_d;
	logic                          hw_q, hw_d;        // Latched mode
	logic                          ldb_q, ldb_d;      // Latched load bit
	logic [`CFG_IDX_W-1:0]         idx_q, idx_d;      // Active bank
	logic [`CFG_IDX_W-1:0]         sel_q, sel_d;      // Last seen pins
	logic                          started_q, started_d; // Startup over
	logic [`CFG_WORD_W-1:0]        word_q, word_d;    // Active config
	cfg_loader_pkg::cfg_src_t      src_q, src_d;      // Its source
	logic                          deny_q, deny_d;    // Denied write
	logic                          align_q, align_d;  // Divider sync
	logic [`CFG_WORD_W-1:0]        bus_def_q;         // Bus defaults
	// One-time store: four banks and their written flags
	logic [`CFG_WORD_W-1:0]        otp_q [`CFG_COUNT];
	logic [`CFG_COUNT-1:0]         otp_set_q;

	logic [`CFG_IDX_W-1:0]         sel_now;           // Pins as index

	// Bank index straight from the pins
	assign sel_now = {config_select_hi, config_select_lo};

	////////////////////////////////////////////////////////////////////
	// One-time store, each bank writable once

	genvar g;
	generate
		for (g = 0; g < `CFG_COUNT; g++) begin : g_bank
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					otp_set_q[g] <= 1'b0;
					otp_q[g]     <= '0;
				end else if (store_wr.valid && !otp_set_q[g] &&
					store_wr.index == `CFG_IDX_W'(g)) begin
					// Program once, later writes ignored
					otp_set_q[g] <= 1'b1;
					otp_q[g]     <= store_wr.data;
				end
			end
		end
	endgenerate

	// Bus default word, fixed reset value
	always_ff @(posedge core_clk) begin
		bus_def_q <= `BUS_DEFAULT_RST;
	end

	////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		por_d      = por_q;
		por_done_d = por_done_q;
		hw_d       = hw_q;
		ldb_d      = ldb_q;
		idx_d      = idx_q;
		sel_d      = sel_q;
		started_d  = started_q;
		word_d     = word_q;
		src_d      = src_q;
		deny_d     = 1'b0;
		align_d    = 1'b0;
		// Startup timer runs once after power-up
		if (!started_q && st_q != cfg_loader_pkg::ST_POR) begin
			if (cnt_q >= CW'(STARTUP_CYC - 1))
				started_d = 1'b1;
		end
		case (st_q)
			cfg_loader_pkg::ST_POR: begin
				// Own reset stretch, entered after sys_rst or from an illegal state
				if (por_q == 5'(`POR_CYC - 1)) begin
					por_done_d = 1'b1;
					st_d       = cfg_loader_pkg::ST_SAMPLE;
				end else begin
					por_d = por_q + 5'h01;
				end
				cnt_d = '0;
			end
			cfg_loader_pkg::ST_SAMPLE: begin
				// Latch strap and pins at reset end
				hw_d  = mode_strap_pin;
				ldb_d = store_load_enable_bit;
				sel_d = sel_now;
				idx_d = mode_strap_pin ? sel_now : '0;
				st_d  = cfg_loader_pkg::ST_LOAD;
				cnt_d = cnt_q + CW'(1);
			end
			cfg_loader_pkg::ST_LOAD: begin
				if (hw_q) begin
					word_d = otp_q[idx_q];
					src_d  = cfg_loader_pkg::SRC_STORE;
				end else if (ldb_q) begin
					word_d = bus_def_q; // Bus defaults
					src_d  = cfg_loader_pkg::SRC_BUS;
				end else begin
					word_d = otp_q[0]; // Bank 0
					src_d  = cfg_loader_pkg::SRC_STORE;
				end
				align_d = hw_q; // Outputs aligned on load in hardware mode only
				st_d    = cfg_loader_pkg::ST_RUN;
				cnt_d   = started_q ? '0 : cnt_q + CW'(1);
			end
			cfg_loader_pkg::ST_RUN: begin
				if (!started_q)
					cnt_d = cnt_q + CW'(1);
				if (hw_q) begin
					// Pins moved after startup: reload
					if (started_q && sel_now != sel_q) begin
						sel_d = sel_now;
						idx_d = sel_now;
						st_d  = cfg_loader_pkg::ST_SETTLE;
						cnt_d = '0;
					end
					deny_d = bus_wr.valid;
				end else if (bus_wr.valid) begin
					// Pins act as bus, writes override
					word_d = bus_wr.data;
					src_d  = cfg_loader_pkg::SRC_BUS;
				end
			end
			cfg_loader_pkg::ST_SETTLE: begin
				// Load new bank then hold off for settle time
				if (cnt_q == '0) begin
					word_d  = otp_q[idx_q];
					align_d = 1'b1;
				end
				deny_d = bus_wr.valid;
				if (cnt_q >= CW'(SETTLE_CYC - 1)) begin
					st_d  = cfg_loader_pkg::ST_RUN;
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q + CW'(1);
				end
			end
			default: st_d = cfg_loader_pkg::ST_POR;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q       <= cfg_loader_pkg::ST_POR;
			cnt_q      <= '0;
			por_q      <= '0;
			por_done_q <= 1'b0;
			hw_q       <= 1'b0;
			ldb_q      <= 1'b0;
			idx_q      <= '0;
			sel_q      <= '0;
			started_q  <= 1'b0;
			word_q     <= '0;
			src_q      <= cfg_loader_pkg::SRC_NONE;
			deny_q     <= 1'b0;
			align_q    <= 1'b0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			por_q      <= por_d;
			por_done_q <= por_done_d;
			hw_q       <= hw_d;
			ldb_q      <= ldb_d;
			idx_q      <= idx_d;
			sel_q      <= sel_d;
			started_q  <= started_d;
			word_q     <= word_d;
			src_q      <= src_d;
			deny_q     <= deny_d;
			align_q    <= align_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hw_mode     <= 1'b0;
			bus_enabled <= 1'b0;
			load_bit_rd <= 1'b0;
			cfg_ready   <= 1'b0;
		end else begin
			hw_mode     <= hw_d;
			// Held shut until the strap is latched, no open cycle
			bus_enabled <= por_done_d && !hw_d &&
				st_q != cfg_loader_pkg::ST_POR;
			load_bit_rd <= hw_d ? 1'b0 : ldb_d; // Reads 0 in hw
			cfg_ready   <= st_d == cfg_loader_pkg::ST_RUN;
		end
	end

	assign cfg_index     = idx_q;
	assign cfg_word      = word_q;
	assign cfg_src       = src_q;
	assign bus_wr_denied = deny_q;
	assign align_pulse   = align_q;

	////////////////////////////////////////////////////////////////////
	// Checks

	a_hw_bus_deny: assert property (@(posedge core_clk) disable iff (sys_rst)
		hw_q && st_q == cfg_loader_pkg::ST_RUN && bus_wr.valid |=>
		bus_wr_denied && $stable(cfg_word))
		else $error("bus write accepted in hardware mode");

	a_sw_override: assert property (@(posedge core_clk) disable iff (sys_rst)
		!hw_q && st_q == cfg_loader_pkg::ST_RUN && bus_wr.valid |=>
		cfg_word == $past(bus_wr.data))
		else $error("bus write did not override");

	a_mode_held: assert property (@(posedge core_clk) disable iff (sys_rst)
		por_done_q && $past(por_done_q, 2) |-> $stable(hw_mode))
		else $error("mode changed after sampling");

	a_bus_closed_hw: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_q == cfg_loader_pkg::ST_SAMPLE || hw_q |-> !bus_enabled)
		else $error("bus enabled in hardware mode");

	a_load_bit_hw: assert property (@(posedge core_clk) disable iff (sys_rst)
		hw_mode |-> !load_bit_rd)
		else $error("load bit reads one in hardware mode");

	a_por_done: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(por_done_q) |-> ##2 cfg_src != cfg_loader_pkg::SRC_NONE)
		else $error("no configuration after internal reset");

	a_hw_index: assert property (@(posedge core_clk) disable iff (sys_rst)
		st_q == cfg_loader_pkg::ST_SAMPLE && mode_strap_pin |=>
		cfg_index == $past(sel_now) ##1 cfg_word == otp_q[cfg_index])
		else $error("wrong bank loaded at power-up");

	a_sel_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
		hw_q && started_q && st_q == cfg_loader_pkg::ST_RUN &&
		sel_now != sel_q |=> cfg_index == $past(sel_now)
		##1 cfg_word == otp_q[cfg_index] && !cfg_ready)
		else $error("select change not reloaded");

	a_otp_once: assert property (@(posedge core_clk) disable iff (sys_rst)
		otp_set_q[0] |=> $stable(otp_q[0]))
		else $error("store bank rewritten");

endmodule // powerup_config_select_loader

// File: bench/sel_strap_model.sv
// Board strap and select-pin driver standing in front of the loader.
// Assumes the bench sets the wanted levels; pins move on core_clk rises.
`timescale 1ns/1ps
module sel_strap_model (
	input  wire logic       core_clk,
	input  wire logic       want_mode,
	input  wire logic [1:0] want_sel,
	output logic            mode_strap_pin = 1'b1,
	output logic            config_select_lo = 1'b0,
	output logic            config_select_hi = 1'b0
);
	// Strap follows the bench; bench holds it still around reset
	// Only one select pin moves per clock, low pin first
	always @(posedge core_clk) begin
		mode_strap_pin <= want_mode;
		if (config_select_lo != want_sel[0])
			config_select_lo <= want_sel[0];
		else
			config_select_hi <= want_sel[1];
	end
endmodule // sel_strap_model

// File: bench/tb_top.sv
// Self-checking bench for the power-up configuration loader.
// Assumes the loader package is compiled first; short startup counts.
`timescale 1ns/1ps
module tb_top;
	logic                       core_clk = 1'b0;
	logic                       sys_rst = 1'b1;
	logic                       want_mode = 1'b1;
	logic [1:0]                 want_sel = 2'h0;
	logic                       load_bit = 1'b0;
	cfg_loader_pkg::bus_wr_t    bus_wr = '0;
	cfg_loader_pkg::store_wr_t  store_wr = '0;
	logic                       strap, sel_lo, sel_hi, hw_mode, bus_en;
	logic                       denied, load_bit_rd, cfg_ready, align;
	logic [1:0]                 cfg_index;
	logic [31:0]                cfg_word;
	cfg_loader_pkg::cfg_src_t   cfg_src;
	int                         fail_count = 0;
	int                         checked = 0;
	int                         denied_n = 0;
	int                         align_n = 0;

	////////////////////////////////////////////////////////////////////
	// Clock, pin model, design
	always #10 core_clk = ~core_clk;

	sel_strap_model u_pins (.core_clk(core_clk), .want_mode(want_mode),
		.want_sel(want_sel), .mode_strap_pin(strap),
		.config_select_lo(sel_lo), .config_select_hi(sel_hi));

	powerup_config_select_loader #(.STARTUP_CYC(50), .SETTLE_CYC(10)) u_dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .mode_strap_pin(strap),
		.config_select_lo(sel_lo), .config_select_hi(sel_hi),
		.store_load_enable_bit(load_bit), .bus_wr(bus_wr),
		.store_wr(store_wr), .hw_mode(hw_mode), .bus_enabled(bus_en),
		.bus_wr_denied(denied), .load_bit_rd(load_bit_rd),
		.cfg_index(cfg_index), .cfg_word(cfg_word), .cfg_src(cfg_src),
		.cfg_ready(cfg_ready), .align_pulse(align));

	// Pulse counters for one-cycle outputs
	always @(posedge core_clk) begin
		if (denied === 1'b1) denied_n++;
		if (align === 1'b1) align_n++;
	end

	////////////////////////////////////////////////////////////////////
	// Shared tasks
	function automatic logic [31:0] bank(input int i);
		return 32'ha5a5_0000 | i;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Wait for ready at a level, bounded
	task automatic wait_rdy(input logic lvl);
		int n;
		for (n = 0; n < 200 && cfg_ready !== lvl; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk({31'h0, cfg_ready}, {31'h0, lvl});
	endtask

	// Write one store bank, a single-cycle request
	task automatic store_prog(input int i, input logic [31:0] d);
		@(posedge core_clk);
		store_wr <= '{1'b1, i[1:0], d};
		@(posedge core_clk);
		store_wr <= '0;
	endtask

	// One bus write, then let the answer land
	task automatic bus_write(input logic [31:0] d);
		@(posedge core_clk);
		bus_wr <= '{1'b1, d};
		@(posedge core_clk);
		bus_wr <= '0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// Reset with straps held steady, program banks, wait for ready
	task automatic rst_up(input logic m, input logic [1:0] s, input logic lb);
		int i;
		@(posedge core_clk);
		sys_rst <= 1'b1;
		want_mode <= m;
		want_sel <= s;
		load_bit <= lb;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1;
		chk({31'h0, cfg_ready}, 32'h0);
		for (i = 0; i < 4; i++) store_prog(i, bank(i));
		wait_rdy(1'b1);
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_hw();
		int i;
		int n;
		for (i = 0; i < 4; i++) begin
			rst_up(1'b1, i[1:0], 1'b1);
			chk(cfg_index, i);
			chk(cfg_word, bank(i));
			chk(hw_mode, 1);
			chk(load_bit_rd, 0);
			chk(bus_en, 0);
			chk(cfg_src, cfg_loader_pkg::SRC_STORE);
		end
		n = denied_n;
		bus_write(32'h1234_5678);
		chk(denied_n - n, 1);
		chk(cfg_word, bank(3));
		store_prog(1, 32'hdead_beef);
		repeat (60) @(posedge core_clk);
		n = align_n;
		want_sel <= 2'h1;
		wait_rdy(1'b0);
		wait_rdy(1'b1);
		chk(cfg_index, 1);
		chk(cfg_word, bank(1));
		chk(align_n - n, 1);
		@(posedge core_clk);
		want_sel <= 2'h0;
		wait_rdy(1'b0);
		wait_rdy(1'b1);
		chk(cfg_word, bank(0));
		$display("test_hw done");
	endtask

	task automatic test_sw();
		rst_up(1'b0, 2'h3, 1'b1);
		chk(hw_mode, 0);
		chk(bus_en, 1);
		chk(load_bit_rd, 1);
		chk(cfg_src, cfg_loader_pkg::SRC_BUS);
		chk(cfg_word, 32'h0);
		bus_write(32'h0bad_cafe);
		chk(cfg_word, 32'h0bad_cafe);
		// Pins are bus lines here, a level change must not reload
		@(posedge core_clk);
		want_sel <= 2'h2;
		repeat (20) @(posedge core_clk);
		#1;
		chk(cfg_word, 32'h0bad_cafe);
		chk({31'h0, cfg_ready}, 32'h1);
		rst_up(1'b0, 2'h2, 1'b0);
		chk(cfg_src, cfg_loader_pkg::SRC_STORE);
		chk(cfg_word, bank(0));
		chk(load_bit_rd, 0);
		bus_write(32'h2468_ace0);
		chk(cfg_word, 32'h2468_ace0);
		chk(cfg_src, cfg_loader_pkg::SRC_BUS);
		$display("test_sw done");
	endtask

	////////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic finish_test();
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		test_hw();
		test_sw();
		finish_test();
	end
endmodule // tb_top
